/* logic/fetx_pkg.sv */
// Constants, code tables and types for the 100 Mb/s transmit coding path
package fetx_pkg;
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          SWRST_TIME_NS = 1000;
  localparam int          SWRST_CYC     = (SWRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          STRAP_SETTLE  = 3;
  localparam int          CG_BITS       = 5;
  localparam int          NIB_BITS      = 4;
  localparam int          BUF_W         = 6;
  localparam int          BUF_EN_BIT    = 5;
  localparam int          BUF_ER_BIT    = 4;
  localparam int          BCR_RESET_BIT = 15;
  localparam int          BCR_PDOWN_BIT = 11;
  localparam logic [15:0] BCR_DEFAULT   = 16'h0000;
  localparam logic [15:0] PCR_DEFAULT   = 16'h0000;
  localparam int          PCR_ADDR_MSB  = 4;
  localparam logic [5:0]  SEED_HIGH     = 6'h2D;
  localparam int          LFSR_W        = 11;
  localparam int          LFSR_TAP_A    = 10;
  localparam int          LFSR_TAP_B    = 8;
  localparam logic [4:0]  CG_IDLE       = 5'h1F;
  localparam logic [4:0]  CG_J          = 5'h18;
  localparam logic [4:0]  CG_K          = 5'h11;
  localparam logic [4:0]  CG_T          = 5'h0D;
  localparam logic [4:0]  CG_R          = 5'h07;
  localparam logic [4:0]  CG_H          = 5'h04;
  localparam logic [4:0]  DATA_CG [16]  = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B,
                                            5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
                                            5'h1A, 5'h1B, 5'h1C, 5'h1D};
  localparam logic [1:0]  MLT_ZERO_A    = 2'h0;
  localparam logic [1:0]  MLT_POS       = 2'h1;
  localparam logic [1:0]  MLT_NEG       = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_J    = 3'h1,
    ST_K    = 3'h3,
    ST_DATA = 3'h2,
    ST_T    = 3'h6,
    ST_R    = 3'h7
  } fetx_state_t;
endpackage

/* logic/fetx_strm_if.sv */
// Valid/ready stream carrier from the MAC inputs to the buffer and from the buffer to the encoder
`timescale 1ns/1ns
interface fetx_strm_if #(parameter int W = 6);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

/* logic/fetx_buf.sv */
// Small FIFO with valid/ready on both sides
`timescale 1ns/1ns
module fetx_buf #(
  parameter int W     = 6,
  parameter int DEPTH = 2
) (
  input wire logic   clk,   // Clock
  input wire logic   rstn,  // Async reset, low
  input wire logic   ce,    // Clock enable
  input wire logic   flush, // Sync clear
  fetx_strm_if.snk   in_s,  // Fill side
  fetx_strm_if.src   out_s  // Drain side
);
  localparam int        AW      = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [W-1:0]  mem_reg [DEPTH];
  logic [W-1:0]  mem_next [DEPTH];
  logic [AW-1:0] wr_ptr_reg, wr_ptr_next;
  logic [AW-1:0] rd_ptr_reg, rd_ptr_next;
  logic [AW:0]   cnt_reg, cnt_next;
  logic          wr;
  logic          rd;

  assign in_s.ready  = (cnt_reg != DEPTH_C);
  assign out_s.valid = (cnt_reg != '0);
  assign out_s.data  = mem_reg[rd_ptr_reg];
  assign wr          = in_s.valid && in_s.ready;
  assign rd          = out_s.valid && out_s.ready;

  always_comb begin
    mem_next    = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    cnt_next    = cnt_reg;
    if (flush) begin
      wr_ptr_next = '0;
      rd_ptr_next = '0;
      cnt_next    = '0;
    end else begin
      if (wr) begin
        mem_next[wr_ptr_reg] = in_s.data;
        wr_ptr_next = (wr_ptr_reg == LAST_C) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (rd) begin
        rd_ptr_next = (rd_ptr_reg == LAST_C) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (wr && !rd) begin
        cnt_next = cnt_reg + 1'b1;
      end else if (rd && !wr) begin
        cnt_next = cnt_reg - 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else if (ce) begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      cnt_reg    <= cnt_next;
    end
  end
endmodule

/* logic/fetx_top.sv */
// Transmit coding path: 4B/5B encode, delimiters, scrambler, NRZI, MLT-3, resets
`timescale 1ns/1ns
module fetx_top
  import fetx_pkg::*;
(
  input  wire logic        CLK,                // 10 MHz clock
  input  wire logic        RSTN,               // Async reset, low
  input  wire logic        CE,                 // Clock enable
  input  wire logic        TX_VALID,           // MAC word valid
  output wire logic        TX_READY,           // Buffer can take word
  input  wire logic        TX_EN,              // Transmit enable
  input  wire logic        TX_ER,              // Transmit error
  input  wire logic [3:0]  TXD,                // Transmit nibble
  input  wire logic [4:0]  STRAP_ADDRESS_PINS, // Address straps
  input  wire logic        SCR_BYPASS,         // Scrambler bypass
  input  wire logic        BCR_WR,             // Basic control write
  input  wire logic [15:0] BCR_WDATA,          // Basic control data
  output wire logic [15:0] BCR_RDATA,          // Basic control readback
  output wire logic [15:0] PCR_RDATA,          // PHY control readback
  output wire logic        SW_RESET_BUSY,      // Software reset running
  input  wire logic [4:0]  RX_CG,              // Received code-group
  input  wire logic        RX_IN_DATA,         // Group lies in data field
  output wire logic        RX_ER,              // Invalid code mark
  output wire logic        LINE_DRIVE_POS,     // Positive drive phase
  output wire logic        LINE_DRIVE_NEG      // Negative drive phase
);
  fetx_strm_if #(.W(BUF_W)) in_if ();
  fetx_strm_if #(.W(BUF_W)) buf_if ();

  logic [4:0]        strap_s1_reg, strap_s2_reg, strap_s3_reg;
  logic [4:0]        strap_q_reg, strap_q_next;
  logic [15:0]       basic_control_reg, basic_control_next;
  logic [15:0]       phy_control_reg, phy_control_next;
  logic [3:0]        swcnt_reg, swcnt_next;
  logic              pend_reg, pend_next;
  logic [1:0]        settle_reg, settle_next;
  logic              seed_load;
  logic              swrst_busy;
  logic              pdown;
  logic              flush;
  fetx_state_t       state_reg, state_next;
  logic [4:0]        cg_reg, cg_next;
  logic [4:0]        sr_reg, sr_next;
  logic [2:0]        bit_cnt_reg, bit_cnt_next;
  logic              load;
  logic              pop;
  logic              hv;
  logic              hen;
  logic              her;
  logic [3:0]        hnib;
  logic [LFSR_W-1:0] lfsr_reg, lfsr_next;
  logic              lfsr_fb;
  logic              scr_bit;
  logic              nrzi_reg, nrzi_next;
  logic [1:0]        phase_reg, phase_next;
  logic              pos_reg, pos_next;
  logic              neg_reg, neg_next;
  logic              rx_er_reg, rx_er_next;

  function automatic logic is_data_cg(input logic [4:0] cg);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 16; i++) begin
      if (DATA_CG[i] == cg) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  assign in_if.valid    = TX_VALID;
  assign in_if.data     = {TX_EN, TX_ER, TXD};
  assign TX_READY       = in_if.ready;
  assign BCR_RDATA      = basic_control_reg;
  assign PCR_RDATA      = phy_control_reg;
  assign SW_RESET_BUSY  = swrst_busy;
  assign RX_ER          = rx_er_reg;
  assign LINE_DRIVE_POS = pos_reg;
  assign LINE_DRIVE_NEG = neg_reg;

  fetx_buf #(.W(BUF_W), .DEPTH(2)) u_buf (
    .clk   (CLK),
    .rstn  (RSTN),
    .ce    (CE),
    .flush (flush),
    .in_s  (in_if),
    .out_s (buf_if)
  );

  // Strap synchroniser; a change counts when stages two and three agree
  always_comb begin
    strap_q_next = (strap_s2_reg == strap_s3_reg) ? strap_s3_reg : strap_q_reg;
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      strap_s1_reg <= 5'h00;
      strap_s2_reg <= 5'h00;
      strap_s3_reg <= 5'h00;
      strap_q_reg  <= 5'h00;
    end else if (CE) begin
      strap_s1_reg <= STRAP_ADDRESS_PINS;
      strap_s2_reg <= strap_s1_reg;
      strap_s3_reg <= strap_s2_reg;
      strap_q_reg  <= strap_q_next;
    end
  end

  // Control registers, software reset timer and strap latch
  assign swrst_busy = (swcnt_reg != 4'h0);
  assign pdown      = basic_control_reg[BCR_PDOWN_BIT];
  assign flush      = swrst_busy || pdown;

  always_comb begin
    basic_control_next = basic_control_reg;
    phy_control_next   = phy_control_reg;
    swcnt_next         = swcnt_reg;
    pend_next          = pend_reg;
    settle_next        = settle_reg;
    seed_load          = 1'b0;
    if (swrst_busy) begin
      if (swcnt_reg == 4'h1) begin
        basic_control_next = BCR_DEFAULT;
        pend_next          = 1'b1;
        settle_next        = 2'(STRAP_SETTLE);
      end
      swcnt_next = swcnt_reg - 4'h1;
    end else if (BCR_WR) begin
      basic_control_next = BCR_WDATA;
      if (BCR_WDATA[BCR_RESET_BIT]) begin
        swcnt_next       = 4'(SWRST_CYC);
        phy_control_next = PCR_DEFAULT;
      end
    end
    // Latch the strap value agreed on at this edge, not the stale one
    if (pend_reg && !swrst_busy) begin
      if (settle_reg == 2'h0) begin
        phy_control_next[PCR_ADDR_MSB:0] = strap_q_next;
        pend_next = 1'b0;
        seed_load = 1'b1;
      end else begin
        settle_next = settle_reg - 2'h1;
      end
    end
  end

  // Power-on and hardware reset re-arm the strap latch
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      basic_control_reg <= BCR_DEFAULT;
      phy_control_reg   <= PCR_DEFAULT;
      swcnt_reg         <= 4'h0;
      pend_reg          <= 1'b1;
      settle_reg        <= 2'(STRAP_SETTLE);
    end else if (CE) begin
      basic_control_reg <= basic_control_next;
      phy_control_reg   <= phy_control_next;
      swcnt_reg         <= swcnt_next;
      pend_reg          <= pend_next;
      settle_reg        <= settle_next;
    end
  end

  // Code-group encoder and delimiter injection
  assign hv   = buf_if.valid;
  assign hen  = buf_if.data[BUF_EN_BIT];
  assign her  = buf_if.data[BUF_ER_BIT];
  assign hnib = buf_if.data[NIB_BITS-1:0];
  assign load = (bit_cnt_reg == 3'(CG_BITS - 1));
  assign buf_if.ready = pop;

  always_comb begin
    state_next   = state_reg;
    cg_next      = cg_reg;
    sr_next      = {sr_reg[3:0], 1'b0};
    bit_cnt_next = load ? 3'h0 : bit_cnt_reg + 3'h1;
    pop          = 1'b0;
    if (load) begin
      case (state_reg)
        ST_IDLE: begin
          if (hv && hen) begin
            pop        = 1'b1;
            cg_next    = CG_J;
            state_next = ST_J;
          end else begin
            pop     = hv;
            cg_next = CG_IDLE;
          end
        end
        ST_J: begin
          pop        = hv && hen;
          cg_next    = CG_K;
          state_next = ST_K;
        end
        ST_K, ST_DATA: begin
          pop = hv;
          if (hv && hen) begin
            cg_next    = her ? CG_H : DATA_CG[hnib];
            state_next = ST_DATA;
          end else begin
            cg_next    = CG_T;
            state_next = ST_T;
          end
        end
        ST_T: begin
          cg_next    = CG_R;
          state_next = ST_R;
        end
        ST_R: begin
          cg_next    = CG_IDLE;
          state_next = ST_IDLE;
        end
        default: begin
          cg_next    = CG_IDLE;
          state_next = ST_IDLE;
        end
      endcase
      sr_next = cg_next;
    end
    if (flush) begin
      state_next   = ST_IDLE;
      cg_next      = CG_IDLE;
      sr_next      = CG_IDLE;
      bit_cnt_next = 3'h0;
      pop          = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_reg   <= ST_IDLE;
      cg_reg      <= CG_IDLE;
      sr_reg      <= CG_IDLE;
      bit_cnt_reg <= 3'h0;
    end else if (CE) begin
      state_reg   <= state_next;
      cg_reg      <= cg_next;
      sr_reg      <= sr_next;
      bit_cnt_reg <= bit_cnt_next;
    end
  end

  // Scrambler, NRZI and MLT-3 phase split
  assign lfsr_fb = lfsr_reg[LFSR_TAP_A] ^ lfsr_reg[LFSR_TAP_B];
  assign scr_bit = SCR_BYPASS ? sr_reg[4] : (sr_reg[4] ^ lfsr_fb);

  always_comb begin
    lfsr_next  = {lfsr_reg[LFSR_W-2:0], lfsr_fb};
    nrzi_next  = nrzi_reg ^ scr_bit;
    phase_next = phase_reg + {1'b0, scr_bit};
    if (seed_load) begin
      lfsr_next = {SEED_HIGH, strap_q_next};
    end else if (flush) begin
      lfsr_next = lfsr_reg;
    end
    if (flush) begin
      nrzi_next  = 1'b0;
      phase_next = MLT_ZERO_A;
    end
    pos_next = (phase_next == MLT_POS);
    neg_next = (phase_next == MLT_NEG);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      lfsr_reg  <= {SEED_HIGH, 5'h00};
      nrzi_reg  <= 1'b0;
      phase_reg <= MLT_ZERO_A;
      pos_reg   <= 1'b0;
      neg_reg   <= 1'b0;
    end else if (CE) begin
      lfsr_reg  <= lfsr_next;
      nrzi_reg  <= nrzi_next;
      phase_reg <= phase_next;
      pos_reg   <= pos_next;
      neg_reg   <= neg_next;
    end
  end

  // Receive-side invalid code marking
  always_comb begin
    rx_er_next = RX_IN_DATA && !is_data_cg(RX_CG);
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rx_er_reg <= 1'b0;
    end else if (CE) begin
      rx_er_reg <= rx_er_next;
    end
  end

  // Checks
  localparam int LATCH_MAX = 6;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN || !CE || flush);

  sequence s_start;
    load && state_reg == ST_IDLE && hv && hen;
  endsequence
  sequence s_jk;
    (cg_reg == CG_J && state_reg == ST_J) ##5 (cg_reg == CG_K);
  endsequence
  sequence s_tr_idle;
    (cg_reg == CG_T) ##5 (cg_reg == CG_R) ##5 (cg_reg == CG_IDLE);
  endsequence

  property p_start_pair;
    s_start |=> s_jk;
  endproperty
  a_start_pair: assert property (p_start_pair) else $error("start pair wrong");

  property p_data_map;
    load && (state_reg == ST_DATA || state_reg == ST_K) && hv && hen && !her
      |=> cg_reg == DATA_CG[$past(hnib)];
  endproperty
  a_data_map: assert property (p_data_map) else $error("data group wrong");

  property p_end_pair;
    load && state_reg == ST_DATA && hv && !hen |=> s_tr_idle;
  endproperty
  a_end_pair: assert property (p_end_pair) else $error("end pair wrong");

  property p_idle_fill;
    load && state_reg == ST_IDLE && !(hv && hen) |=> cg_reg == CG_IDLE && state_reg == ST_IDLE;
  endproperty
  a_idle_fill: assert property (p_idle_fill) else $error("idle missing");

  property p_scramble;
    !SCR_BYPASS && !seed_load |=> nrzi_reg == ($past(nrzi_reg) ^ $past(sr_reg[4])
      ^ $past(lfsr_reg[LFSR_TAP_A]) ^ $past(lfsr_reg[LFSR_TAP_B]));
  endproperty
  a_scramble: assert property (p_scramble) else $error("scramble wrong");

  property p_bypass;
    SCR_BYPASS |=> nrzi_reg == ($past(nrzi_reg) ^ $past(sr_reg[4]));
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass wrong");

  property p_lfsr_live;
    disable iff (!RSTN) lfsr_reg != 11'h000;
  endproperty
  a_lfsr_live: assert property (p_lfsr_live) else $error("lfsr zero");

  property p_mlt_split;
    disable iff (!RSTN) !(LINE_DRIVE_POS && LINE_DRIVE_NEG)
      and ($rose(LINE_DRIVE_POS) |-> $past(phase_reg) == MLT_ZERO_A);
  endproperty
  a_mlt_split: assert property (p_mlt_split) else $error("mlt phase wrong");

  property p_swrst_time;
    disable iff (!RSTN || !CE)
    $rose(swrst_busy) |-> swrst_busy[*8] ##1 swrst_busy ##1 swrst_busy ##1 !swrst_busy;
  endproperty
  a_swrst_time: assert property (p_swrst_time) else $error("soft reset length");

  property p_strap_latch;
    disable iff (!RSTN || !CE)
    $fell(swrst_busy) |-> ##[1:LATCH_MAX] phy_control_reg[PCR_ADDR_MSB:0] == strap_q_reg;
  endproperty
  a_strap_latch: assert property (p_strap_latch) else $error("strap not latched");

  property p_pdown;
    disable iff (!RSTN || !CE) pdown |=> !LINE_DRIVE_POS && !LINE_DRIVE_NEG;
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down drives line");

  property p_rx_invalid;
    disable iff (!RSTN || !CE)
    RX_IN_DATA && (RX_CG == CG_IDLE || RX_CG == CG_J || RX_CG == CG_T) |=> RX_ER;
  endproperty
  a_rx_invalid: assert property (p_rx_invalid) else $error("invalid code unmarked");
endmodule

/* tb/fetx_mac_model.sv */
// MAC-side nibble source that holds each word until the buffer takes it
`timescale 1ns/1ns
module fetx_mac_model (
  input  wire logic       clk,      // Clock
  input  wire logic       tx_ready, // Buffer can take word
  output logic            tx_valid, // Word valid
  output logic            tx_en,    // Transmit enable
  output logic            tx_er,    // Transmit error
  output logic [3:0]      txd       // Nibble
);
  logic [5:0] q[$];
  logic       hs;

  task automatic push(input logic en, input logic er, input logic [3:0] nib);
    q.push_back({en, er, nib});
  endtask

  initial begin
    {tx_valid, tx_en, tx_er, txd, hs} = '0;
    forever begin
      @(posedge clk);
      if (hs) begin
        void'(q.pop_front());
      end
      #10;
      if (q.size() > 0) begin
        {tx_valid, tx_en, tx_er, txd} = {1'b1, q[0]};
      end else begin
        {tx_valid, tx_en, tx_er} = 3'h0;
        txd = ~txd; // Released nibble keeps changing
      end
      #80 hs = tx_valid & tx_ready;
    end
  end
endmodule

/* tb/fetx_top_bench.sv */
// Self-checking bench for the transmit coding path
`timescale 1ns/1ns
module fetx_top_bench;
  logic        CLK, RSTN, CE, TX_VALID, TX_READY, TX_EN, TX_ER;
  logic [3:0]  TXD;
  logic [4:0]  STRAP_ADDRESS_PINS, RX_CG, grp;
  logic        SCR_BYPASS, BCR_WR, SW_RESET_BUSY, RX_IN_DATA, RX_ER;
  logic [15:0] BCR_WDATA, BCR_RDATA, PCR_RDATA;
  logic        LINE_DRIVE_POS, LINE_DRIVE_NEG;
  logic [4:0]  dcg [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
                            5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic [4:0]  exp_q[$], got_q[$];
  logic        key_q[$];
  logic [9:0]  sr;
  logic [1:0]  ph, last_nz;
  logic        s, hunt, cap_on, key_on, saw_full, resync, hit;
  int          err_count, n_compared, cycles, bitcnt, ones;

  fetx_top uut (
    .CLK(CLK), .RSTN(RSTN), .CE(CE), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
    .TX_EN(TX_EN), .TX_ER(TX_ER), .TXD(TXD), .STRAP_ADDRESS_PINS(STRAP_ADDRESS_PINS),
    .SCR_BYPASS(SCR_BYPASS), .BCR_WR(BCR_WR), .BCR_WDATA(BCR_WDATA),
    .BCR_RDATA(BCR_RDATA), .PCR_RDATA(PCR_RDATA), .SW_RESET_BUSY(SW_RESET_BUSY),
    .RX_CG(RX_CG), .RX_IN_DATA(RX_IN_DATA), .RX_ER(RX_ER),
    .LINE_DRIVE_POS(LINE_DRIVE_POS), .LINE_DRIVE_NEG(LINE_DRIVE_NEG)
  );

  fetx_mac_model mac (
    .clk(CLK), .tx_ready(TX_READY), .tx_valid(TX_VALID), .tx_en(TX_EN),
    .tx_er(TX_ER), .txd(TXD)
  );

  always #50 CLK = ~CLK;

  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_cg(input logic [4:0] got, input logic [4:0] exp);
    cmp_word({11'h0, got}, {11'h0, exp});
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0, got}, {15'h0, exp});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #10;
  endtask

  task automatic write_bcr(input logic [15:0] d);
    @(posedge CLK) #10;
    BCR_WR = 1'b1;
    BCR_WDATA = d;
    @(posedge CLK) #10;
    BCR_WR = 1'b0;
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      close_out();
    end
  end

  // Line decoder: any phase change is a serial one
  always @(negedge CLK) begin
    s = ({LINE_DRIVE_POS, LINE_DRIVE_NEG} != ph);
    resync = resync | !RSTN | SW_RESET_BUSY | BCR_RDATA[11];
    if (s && ph != 2'h0) cmp_word({14'h0, LINE_DRIVE_POS, LINE_DRIVE_NEG}, 16'h0);
    if (s && ph == 2'h0) begin
      if (!resync) cmp_bit(LINE_DRIVE_POS, last_nz[0]);
      last_nz = {LINE_DRIVE_POS, LINE_DRIVE_NEG};
      resync = 1'b0;
    end
    ph = {LINE_DRIVE_POS, LINE_DRIVE_NEG};
    sr = {sr[8:0], s};
    if (key_on) key_q.push_back(s);
    if (!TX_READY) saw_full = 1'b1;
    if (cap_on) begin
      grp = {grp[3:0], s};
      bitcnt++;
      if (bitcnt == 5) begin
        got_q.push_back(grp);
        bitcnt = 0;
      end
      if (got_q.size() == exp_q.size()) cap_on = 1'b0;
    end else if (hunt && sr == 10'h311) begin
      hunt = 1'b0;
      cap_on = 1'b1;
      bitcnt = 0;
    end
  end

  initial begin
    {CLK, RSTN, BCR_WR, BCR_WDATA, RX_CG, RX_IN_DATA} = '0;
    {hunt, cap_on, key_on, saw_full, sr, ph} = '0;
    {CE, SCR_BYPASS, resync, last_nz} = {3'h7, 2'h1};
    STRAP_ADDRESS_PINS = 5'h13;
    tick(16);
    RSTN = 1'b1;
    tick(8);
    cmp_word(PCR_RDATA, 16'h0013);
    cmp_word(BCR_RDATA, 16'h0000);
    // Receive marking over every group value
    RX_IN_DATA = 1'b1;
    for (int c = 0; c < 32; c++) begin
      RX_CG = 5'(c);
      hit = 1'b0;
      foreach (dcg[k]) hit |= (dcg[k] == 5'(c));
      tick(1);
      cmp_bit(RX_ER, !hit);
    end
    RX_IN_DATA = 1'b0;
    RX_CG = 5'h1F;
    tick(1);
    cmp_bit(RX_ER, 1'b0);
    // Unscrambled frame: J/K, all data groups, halt, T/R, idle
    foreach (dcg[i]) exp_q.push_back(dcg[i]);
    exp_q.push_back(5'h04);
    exp_q.push_back(5'h0D);
    exp_q.push_back(5'h07);
    exp_q.push_back(5'h1F);
    hunt = 1'b1;
    mac.push(1'b0, 1'b0, 4'h3);
    mac.push(1'b1, 1'b0, 4'h5);
    mac.push(1'b1, 1'b0, 4'h5);
    for (int i = 0; i < 16; i++) mac.push(1'b1, 1'b0, 4'(i));
    mac.push(1'b1, 1'b1, 4'h0);
    mac.push(1'b0, 1'b0, 4'h0);
    for (int w = 0; w < 400 && got_q.size() < exp_q.size(); w++) @(posedge CLK);
    tick(1);
    foreach (exp_q[i]) cmp_cg(got_q[i], exp_q[i]);
    cmp_bit(hunt, 1'b0);
    cmp_bit(saw_full, 1'b1);
    cmp_bit(TX_READY, 1'b1);
    // Scrambled idle must follow the 11-bit recurrence
    SCR_BYPASS = 1'b0;
    tick(20);
    key_on = 1'b1;
    tick(60);
    key_on = 1'b0;
    ones = 0;
    foreach (key_q[n]) ones += int'(key_q[n]);
    cmp_bit(ones < 60, 1'b1);
    for (int n = 11; n < 60; n++) cmp_bit(key_q[n], ~(key_q[n-11] ^ key_q[n-9]));
    // Power-down silences the line
    write_bcr(16'h0800);
    cmp_word(BCR_RDATA, 16'h0800);
    tick(3);
    repeat (20) begin
      @(negedge CLK);
      cmp_bit(LINE_DRIVE_POS | LINE_DRIVE_NEG, 1'b0);
    end
    write_bcr(16'h0000);
    // Software reset with a write refused while busy
    write_bcr(16'h8000);
    cmp_word(BCR_RDATA, 16'h8000);
    cmp_bit(SW_RESET_BUSY, 1'b1);
    cmp_word(PCR_RDATA, 16'h0000);
    write_bcr(16'h0800);
    tick(7);
    cmp_bit(SW_RESET_BUSY, 1'b1);
    tick(1);
    cmp_bit(SW_RESET_BUSY, 1'b0);
    cmp_word(BCR_RDATA, 16'h0000);
    tick(30);
    cmp_word(PCR_RDATA, 16'h0013);
    // Hardware reset re-latches a new strap
    write_bcr(16'h0800);
    STRAP_ADDRESS_PINS = 5'h0A;
    RSTN = 1'b0;
    tick(10);
    cmp_word(BCR_RDATA, 16'h0000);
    RSTN = 1'b1;
    tick(8);
    cmp_word(PCR_RDATA, 16'h000A);
    cmp_word(BCR_RDATA, 16'h0000);
    close_out();
  end
endmodule
